//--- hdl/sddc_top.sv
// Supply drop detector control logic with APB register slave
//
// Operation
// - The flag sets on a falling crossing below the trip, not on level.
// - The flag stays set until software writes it to zero.
// - Interrupt only while flag and all three enable bits are set.
// - Software writing one to the flag acts like a real drop event.
// - Reference-stable reads one once settled, valid with fast osc on.
// - In sleep a set flag with both local enables wakes the core.
// - Such a wake with global enable runs one instruction, then vectors.
// - Control register resets to 00-100 with unused bits reading zero.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module sddc_top #(
    parameter int SETTLE_CYCLES = sddc_pkg::SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog side
    input  wire logic        comp_below_raw,
    input  wire logic        fast_internal_oscillator,
    output logic             detector_power,
    output logic [2:0]       trip_level_select,
    // Core side
    output logic             irq,
    output logic             wake,
    output logic             vector_req
);
    // ------------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------------
    sddc_sync_if sync_bus ();

    sddc_sync u_sync (
        .pclk           (pclk),
        .presetn        (presetn),
        .comp_below_raw (comp_below_raw),
        .sync_o         (sync_bus)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SDDC_AWAKE, SDDC_RUN_ONE, SDDC_VECTOR}
        sddc_wake_e;

    logic        enable_q,   enable_d;
    logic [2:0]  level_q,    level_d;
    logic        flag_q,     flag_d;
    logic        lvie_q,     lvie_d;
    logic        periph_ie_q, periph_ie_d;
    logic        global_ie_q, global_ie_d;
    logic        sleep_q,    sleep_d;
    logic        below_q;
    logic [31:0] settle_q,   settle_d;
    logic        stable_q,   stable_d;
    logic [31:0] prdata_q,   prdata_d;
    sddc_wake_e  wst_q,      wst_d;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire wr_acc   = psel & penable & pwrite;
    wire sel_ctrl = (paddr == sddc_pkg::LOW_VOLTAGE_CONTROL_OFS);
    wire sel_flag = (paddr == sddc_pkg::FLAG_OFS);
    wire sel_ie   = (paddr == sddc_pkg::INT_ENABLE_OFS);
    wire sel_slp  = (paddr == sddc_pkg::SLEEP_CTRL_OFS);
    wire mapped   = sel_ctrl | sel_flag | sel_ie | sel_slp;
    wire wr_ctrl  = wr_acc & sel_ctrl;
    wire wr_flag  = wr_acc & sel_flag;
    wire wr_ie    = wr_acc & sel_ie;
    wire wr_slp   = wr_acc & sel_slp;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_q;

    // ------------------------------------------------------------------
    // Detection
    // ------------------------------------------------------------------
    // Falling crossing edge detect
    wire fall_evt = enable_q & sync_bus.below_trip & ~below_q;
    wire sw_set   = wr_flag & pwdata[sddc_pkg::FLAG_BIT];
    wire sw_clr   = wr_flag & ~pwdata[sddc_pkg::FLAG_BIT];
    assign flag_d = (fall_evt | sw_set) ? 1'b1 : (sw_clr ? 1'b0 : flag_q);

    assign enable_d = wr_ctrl ? pwdata[sddc_pkg::ENABLE_BIT] : enable_q;
    assign level_d  = wr_ctrl ?
        pwdata[sddc_pkg::LVL_MSB:sddc_pkg::LVL_LSB] : level_q;
    assign lvie_d   = wr_ie ? pwdata[sddc_pkg::LVIE_BIT] : lvie_q;
    assign periph_ie_d = wr_ie ?
        pwdata[sddc_pkg::PERIPH_IE_BIT] : periph_ie_q;
    assign global_ie_d = wr_ie ?
        pwdata[sddc_pkg::GLOBAL_IE_BIT] : global_ie_q;

    assign detector_power    = enable_q;
    assign trip_level_select = level_q;

    wire settled = (settle_q >= 32'(SETTLE_CYCLES));
    assign settle_d = !enable_q ? 32'h0000_0000 :
                      (settled ? settle_q : settle_q + 32'h0000_0001);
    assign stable_d = enable_q & settled & fast_internal_oscillator;

    // ------------------------------------------------------------------
    // Interrupt, wake and vector
    // ------------------------------------------------------------------
    // Four-way interrupt gate
    assign irq = flag_q & lvie_q & periph_ie_q & global_ie_q;
    wire wake_cond = sleep_q & flag_q & lvie_q & periph_ie_q;
    assign wake    = wake_cond;
    assign sleep_d = wake_cond ? 1'b0 :
                     (wr_slp ? pwdata[sddc_pkg::SLEEP_BIT] : sleep_q);

    always_comb begin
        wst_d = wst_q;
        case (wst_q)
            SDDC_AWAKE:   if (wake_cond && global_ie_q) wst_d = SDDC_RUN_ONE;
            SDDC_RUN_ONE: wst_d = SDDC_VECTOR;
            SDDC_VECTOR:  wst_d = SDDC_AWAKE;
            default:      wst_d = SDDC_AWAKE;
        endcase
    end
    assign vector_req = (wst_q == SDDC_VECTOR);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Unused control bits read zero
    wire [31:0] ctrl_rd = {26'h0, stable_q, enable_q, 1'b0, level_q};
    wire [31:0] flag_rd = {31'h0, flag_q};
    wire [31:0] ie_rd   = {29'h0, global_ie_q, periph_ie_q, lvie_q};
    wire [31:0] slp_rd  = {31'h0, sleep_q};
    assign prdata_d = !(psel & ~penable & ~pwrite) ? prdata_q :
                      sel_ctrl ? ctrl_rd :
                      sel_flag ? flag_rd :
                      sel_ie   ? ie_rd   :
                      sel_slp  ? slp_rd  : 32'h0000_0000;

    // ------------------------------------------------------------------
    // Flops
    // ------------------------------------------------------------------
    // Control reset value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= 1'b0;
            level_q  <= sddc_pkg::LVL_RESET;
            stable_q <= 1'b0;
        end else begin
            enable_q <= enable_d;
            level_q  <= level_d;
            stable_q <= stable_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q  <= 1'b0;
            below_q <= 1'b0;
        end else begin
            flag_q  <= flag_d;
            below_q <= sync_bus.below_trip;
        end
    end

    // Interrupt enables and sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvie_q      <= 1'b0;
            periph_ie_q <= 1'b0;
            global_ie_q <= 1'b0;
            sleep_q     <= 1'b0;
        end else begin
            lvie_q      <= lvie_d;
            periph_ie_q <= periph_ie_d;
            global_ie_q <= global_ie_d;
            sleep_q     <= sleep_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_q <= 32'h0000_0000;
        end else begin
            settle_q <= settle_d;
        end
    end

    // Read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wst_q <= SDDC_AWAKE;
        end else begin
            wst_q <= wst_d;
        end
    end
endmodule // sddc_top

//--- hdl/sddc_pkg.sv
// Package: register map, field layout and reset values of the drop detector
package sddc_pkg;
    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] LOW_VOLTAGE_CONTROL_OFS = 12'h000;
    localparam logic [11:0] FLAG_OFS                = 12'h004;
    localparam logic [11:0] INT_ENABLE_OFS          = 12'h008;
    localparam logic [11:0] SLEEP_CTRL_OFS          = 12'h00C;
    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int          LVL_LSB     = 0;
    localparam int          LVL_MSB     = 2;
    localparam int          ENABLE_BIT  = 4;
    localparam int          STABLE_BIT  = 5;
    localparam logic [2:0]  LVL_RESET   = 3'h4;
    localparam logic [7:0]  CTRL_RESET  = 8'h04;
    // ------------------------------------------------------------------
    // Other register fields
    // ------------------------------------------------------------------
    localparam int          FLAG_BIT    = 0;
    localparam int          LVIE_BIT    = 0;
    localparam int          PERIPH_IE_BIT = 1;
    localparam int          GLOBAL_IE_BIT = 2;
    localparam int          SLEEP_BIT   = 0;
    // ------------------------------------------------------------------
    // Reference settling time
    // ------------------------------------------------------------------
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          SETTLE_US       = 50;
    localparam int          SETTLE_CYCLES   = (SETTLE_US * (CLK_HZ / 1_000_000));
    // Wake sequence
    localparam int          WAKE_INSN_CYCLES = 1;
endpackage

//--- hdl/sddc_sync_if.sv
// Interface: synchronised comparator level between synchroniser and core
`timescale 1ns/1ps
interface sddc_sync_if;
    logic below_trip;
    modport src (output below_trip);
    modport dst (input  below_trip);
endinterface

//--- hdl/sddc_sync.sv
// Two-stage synchroniser for the analog comparator output
`timescale 1ns/1ps
module sddc_sync (
    // Clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // Raw comparator
    input  wire logic   comp_below_raw,
    // Synchronised level
    sddc_sync_if.src    sync_o
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= comp_below_raw;
            sync_q <= meta_q;
        end
    end

    assign sync_o.below_trip = sync_q;
endmodule // sddc_sync

//--- verif/sddc_chk.sv
// Checker: port-level assertions for the drop detector control
`timescale 1ns/1ps
module sddc_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Analog side
    input wire logic        fast_internal_oscillator,
    input wire logic        detector_power,
    input wire logic [2:0]  trip_level_select,
    // Core side
    input wire logic        irq,
    input wire logic        wake,
    input wire logic        vector_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc    = psel && penable;
    wire wr_ctl = acc && pwrite && paddr == 12'h000;
    wire wr_ie  = acc && pwrite && paddr == 12'h008;
    wire wr_irq = acc && pwrite && paddr inside {12'h004, 12'h008};
    wire rd_ctl = psel && !penable && !pwrite && paddr == 12'h000;
    property p_power;
        wr_ctl |=> detector_power == $past(pwdata[4]); endproperty
    a_power: assert property (p_power) else $error("power bad");
    property p_level;
        wr_ctl |=> trip_level_select == $past(pwdata[2:0]); endproperty
    a_level: assert property (p_level) else $error("level bad");
    property p_hold; irq && !wr_irq |=> irq; endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_gate; wr_ie && pwdata[2:0] != 3'h7 |=> !irq; endproperty
    a_gate: assert property (p_gate) else $error("irq open");
    property p_stable; rd_ctl && !fast_internal_oscillator &&
        !$past(fast_internal_oscillator) |=> !prdata[5]; endproperty
    a_stable: assert property (p_stable) else $error("stable bad");
    property p_off; rd_ctl && !detector_power &&
        !$past(detector_power) |=> !prdata[5]; endproperty
    a_off: assert property (p_off) else $error("stable when off");
    property p_wake; wake |=> !wake; endproperty
    a_wake: assert property (p_wake) else $error("wake long");
    property p_vector; vector_req |-> $past(wake, 2); endproperty
    a_vector: assert property (p_vector) else $error("vector bad");
    property p_bits;
        rd_ctl |=> prdata[31:6] == 26'h0 && !prdata[3]; endproperty
    a_bits: assert property (p_bits) else $error("unused bits");
    property p_ready; acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("ready low");
    property p_slverr; acc && paddr[1:0] == 2'h0 |->
        pslverr == (paddr > 12'h00C); endproperty
    a_slverr: assert property (p_slverr) else $error("slverr bad");
    c_irq: cover property (irq);
    c_vec: cover property (wake ##2 vector_req);
    c_err: cover property (acc && pslverr);
endmodule // sddc_chk
bind sddc_top sddc_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .pready, .pslverr, .paddr, .pwdata, .prdata, .fast_internal_oscillator,
    .detector_power, .irq, .wake, .vector_req, .trip_level_select);

//--- verif/tb_top.sv
// Testbench: register, detection, interrupt and wake tests
`timescale 1ns/1ps
module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, comp = 1'b0, osc = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_val;
    logic        pready, pslverr, err_seen, detector_power, irq, wake;
    logic        vector_req;
    logic [2:0]  trip_level_select;
    int          n_errors = 0, num_checks = 0, cyc = 0;
    always #50 pclk = ~pclk;
    sddc_top #(.SETTLE_CYCLES(4)) dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .comp_below_raw(comp), .fast_internal_oscillator(osc),
        .detector_power, .trip_level_select, .irq, .wake, .vector_req);
    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_val   = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string n, input logic [11:0] a, logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(n, e, rd_val);
    endtask
    task automatic results;
        $display("Checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc("ctrl", 12'h000, 32'h04);
        chk("level", 32'h4, 32'(trip_level_select));
        rdc("unmapped", 12'h010, 32'h0);
        chk("slverr", 32'h1, 32'(err_seen));
        $display("Test reset done");
        for (int l = 0; l < 8; l++) begin
            xfer(1'b1, 12'h000, 32'h10 | 32'(l));
            @(negedge pclk);
            chk("level", 32'(l), 32'(trip_level_select));
            chk("power", 32'h1, 32'(detector_power));
        end
        @(posedge pclk) osc <= 1'b1;
        repeat (8) @(negedge pclk);
        rdc("stable", 12'h000, 32'h37);
        @(posedge pclk) osc <= 1'b0;
        repeat (3) @(negedge pclk);
        rdc("osc off", 12'h000, 32'h17);
        $display("Test control done");
        xfer(1'b1, 12'h004, 32'h0);
        @(posedge pclk) comp <= 1'b1;
        repeat (5) @(negedge pclk);
        rdc("edge", 12'h004, 32'h1);
        @(posedge pclk) comp <= 1'b0;
        repeat (5) @(negedge pclk);
        rdc("held", 12'h004, 32'h1);
        @(posedge pclk) comp <= 1'b1;
        repeat (5) @(negedge pclk);
        xfer(1'b1, 12'h004, 32'h0);
        repeat (5) @(negedge pclk);
        rdc("level only", 12'h004, 32'h0);
        $display("Test detect done");
        xfer(1'b1, 12'h004, 32'h1);
        for (int e = 0; e < 8; e++) begin
            xfer(1'b1, 12'h008, 32'(e));
            @(negedge pclk);
            chk("irq", 32'(e == 7), 32'(irq));
        end
        for (int g = 0; g < 2; g++) begin
            xfer(1'b1, 12'h004, 32'h0);
            xfer(1'b1, 12'h008, 32'h3 | 32'(g << 2));
            xfer(1'b1, 12'h00C, 32'h1);
            xfer(1'b1, 12'h004, 32'h1);
            for (int i = 0; i < 8 && wake !== 1'b1; i++) @(negedge pclk);
            chk("wake", 32'h1, 32'(wake));
            repeat (2) @(negedge pclk);
            chk("vector", 32'(g), 32'(vector_req));
            rdc("sleep", 12'h00C, 32'h0);
        end
        $display("Test irq and wake done");
        xfer(1'b1, 12'h004, 32'h0);
        xfer(1'b1, 12'h000, 32'h04);
        @(posedge pclk);
        osc  <= 1'b1;
        comp <= 1'b0;
        repeat (5) @(negedge pclk);
        chk("power off", 32'h0, 32'(detector_power));
        rdc("off ctrl", 12'h000, 32'h04);
        @(posedge pclk) comp <= 1'b1;
        repeat (5) @(negedge pclk);
        rdc("gated", 12'h004, 32'h0);
        xfer(1'b1, 12'h000, 32'h14);
        rdc("settling", 12'h000, 32'h14);
        repeat (8) @(negedge pclk);
        rdc("settled", 12'h000, 32'h34);
        xfer(1'b1, 12'h008, 32'h1);
        xfer(1'b1, 12'h00C, 32'h1);
        xfer(1'b1, 12'h004, 32'h1);
        repeat (3) @(negedge pclk);
        chk("no wake", 32'h0, 32'(wake));
        rdc("asleep", 12'h00C, 32'h1);
        $display("Test power and sleep done");
        results();
    end
endmodule // tb_top
